// >>> common/dyn_term_defines.svh
/*
 * Constants of the dynamic termination pair: mode-register field positions,
 * latency figures and the controller's APB register map.
 * Assumes inclusion by bare name from design files.
 */
`ifndef DYN_TERM_DEFINES_SVH
`define DYN_TERM_DEFINES_SVH

// Mode register field positions.
`define MR1_NOM_HI        9
`define MR1_NOM_MID       6
`define MR1_NOM_LO        2
`define MR1_LEVEL_BIT     7
`define MR1_DLL_OFF_BIT   0
`define MR1_AL_HI         4
`define MR1_AL_LO         3
`define MR2_WR_HI         10
`define MR2_WR_LO         9
`define MR2_CWL_HI        5
`define MR2_CWL_LO        3
`define MR0_CL_HI         6
`define MR0_CL_LO         4
`define MR_WIDTH          13

// Latency figures in clocks.
`define CWL_BASE          5'h05
`define CL_BASE           5'h04
`define LAT_OFFSET        5'h02
`define CHOP_RETURN       5'h04
`define FULL_RETURN       5'h06
`define HIGH_TIME_SHORT   4'h4
`define HIGH_TIME_LONG    4'h6
`define SKEW_CLOCKS       5'h01
`define EXTRA_CLOCKS      5'h01
`define MODE_SET_DEFAULT  12

// Controller register offsets (byte addresses).
`define REG_CMD           12'h000
`define REG_TERM_CTRL     12'h004
`define REG_STATUS        12'h008
`define REG_MR1_SHADOW    12'h00C
`define REG_MR2_SHADOW    12'h010

// Command register fields.
`define CMD_KIND_LO       0
`define CMD_CHOP_BIT      2
`define CMD_SEL_LO        3
`define CMD_DATA_LO       16

// Status bits.
`define ST_BUSY           0
`define ST_LINE           1
`define ST_WR_STRIPPED    2
`define ST_NOM_WARN       3
`define ST_NOM_STRIPPED   4

`endif

// >>> common/dyn_term_pkg.sv
/*
 * Types shared by both ends of the termination link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dyn_term_pkg;

  // Link command kinds.
  typedef enum logic [1:0] {
    CMD_NONE  = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_MODE  = 2'h2
  } cmd_kind_t;

  // Termination strength applied to a lane group.
  typedef enum logic [2:0] {
    RTT_OFF      = 3'h0,
    RTT_DIV4     = 3'h1,
    RTT_DIV2     = 3'h2,
    RTT_DIV6     = 3'h3,
    RTT_DIV12    = 3'h4,
    RTT_DIV8     = 3'h5,
    RTT_RESERVED = 3'h7
  } rtt_t;

endpackage

// >>> common/term_link_if.sv
/*
 * Link between the memory controller and the device termination logic.
 * Assumes both ends share one clock; the bench instantiates and joins them.
 */
`timescale 1ns/100ps
interface term_link_if;
  import dyn_term_pkg::*;

  logic            cmd_valid;
  cmd_kind_t       cmd_kind;
  logic            cmd_chop;
  logic [1:0]      mr_sel;
  logic [12:0]     mr_data;
  logic            termination_control_input;

  // Device end samples everything.
  modport device (
    input cmd_valid, cmd_kind, cmd_chop, mr_sel, mr_data, termination_control_input
  );

  // Controller end drives everything.
  modport controller (
    output cmd_valid, cmd_kind, cmd_chop, mr_sel, mr_data, termination_control_input
  );
endinterface

// >>> logic/dyn_term_device.sv
/*
 * Device end: on-die termination selection with nominal and write strengths.
 * Assumes commands and the control input are synchronous to pclk and that the
 * controller keeps its own timing obligations on the link.
 */
// Added by the designer: the register addresses.
`timescale 1ns/100ps
`include "dyn_term_defines.svh"

module dyn_term_device #(
  parameter int MAX_LAT         = 32,
  parameter int MODE_SET_CYCLES = `MODE_SET_DEFAULT
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           ce,
  term_link_if.device         link,
  output dyn_term_pkg::rtt_t  dq_strength,
  output dyn_term_pkg::rtt_t  strobe_strength,
  output logic                dq_term_on,
  output logic                strobe_term_on,
  output logic                term_changing,
  output logic                term_uncertain
);
  import dyn_term_pkg::*;

  logic [`MR_WIDTH-1:0] mr0;
  logic [`MR_WIDTH-1:0] mr1;
  logic [`MR_WIDTH-1:0] mr2;
  logic [2:0]           nom_code;
  logic [1:0]           wr_code;
  logic                 dyn_enabled;
  logic                 leveling;
  logic [4:0]           cwl;
  logic [4:0]           cl;
  logic [4:0]           al;
  logic [4:0]           lat;
  logic [MAX_LAT-1:0]   ctl_hist;
  logic                 ctl_delayed;
  logic [4:0]           start_count;
  logic [4:0]           end_count;
  logic                 use_write;
  logic [7:0]           settle_count;
  rtt_t                 nom_rtt;
  rtt_t                 wr_rtt;
  rtt_t                 next_dq;
  rtt_t                 next_strobe;
  logic                 write_cmd;
  logic                 mode1_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers and decoded fields.

  // Mode registers are loaded by mode commands on the link.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr0 <= '0;
      mr1 <= '0;
      mr2 <= '0;
    end else if (ce && link.cmd_valid && link.cmd_kind == CMD_MODE) begin
      unique case (link.mr_sel)
        2'h0: mr0 <= link.mr_data;
        2'h1: mr1 <= link.mr_data;
        2'h2: mr2 <= link.mr_data;
        2'h3: ;
      endcase
    end
  end

  // Field decode and latency arithmetic.
  always_comb begin
    nom_code    = {mr1[`MR1_NOM_HI], mr1[`MR1_NOM_MID], mr1[`MR1_NOM_LO]};
    wr_code     = {mr2[`MR2_WR_HI], mr2[`MR2_WR_LO]};
    dyn_enabled = |wr_code;
    leveling    = mr1[`MR1_LEVEL_BIT];
    cwl         = 5'({2'h0, mr2[`MR2_CWL_HI:`MR2_CWL_LO]}) + `CWL_BASE;
    cl          = 5'({2'h0, mr0[`MR0_CL_HI:`MR0_CL_LO]}) + `CL_BASE;
    unique case (mr1[`MR1_AL_HI:`MR1_AL_LO])
      2'h1:    al = cl - 5'h01;
      2'h2:    al = cl - 5'h02;
      default: al = 5'h00;
    endcase
    lat = cwl + al - `LAT_OFFSET;
  end

  // Nominal strength lookup.
  always_comb begin
    unique case (nom_code)
      3'h0:    nom_rtt = RTT_OFF;
      3'h1:    nom_rtt = RTT_DIV4;
      3'h2:    nom_rtt = RTT_DIV2;
      3'h3:    nom_rtt = RTT_DIV6;
      3'h4:    nom_rtt = RTT_DIV12;
      3'h5:    nom_rtt = RTT_DIV8;
      default: nom_rtt = RTT_RESERVED;
    endcase
  end

  // Write strength lookup; code zero never reaches the output.
  always_comb begin
    unique case (wr_code)
      2'h1:    wr_rtt = RTT_DIV4;
      2'h2:    wr_rtt = RTT_DIV2;
      default: wr_rtt = RTT_RESERVED;
    endcase
  end

  assign write_cmd = link.cmd_valid && link.cmd_kind == CMD_WRITE;
  assign mode1_cmd = link.cmd_valid && link.cmd_kind == CMD_MODE && link.mr_sel == 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Control input latency.

  // History of the registered control input, one entry per clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_hist <= '0;
    end else if (ce) begin
      ctl_hist <= {ctl_hist[MAX_LAT-2:0], link.termination_control_input};
    end
  end

  // Input seen high at edge n raises ctl_delayed at edge n plus latency; termination turns on one edge later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_delayed <= 1'b0;
    end else if (ce) begin
      ctl_delayed <= ctl_hist[lat - 5'h01];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write strength window.

  // Start countdown: a pending or running window keeps its earlier start; a
  // write on the closing edge opens a fresh window after nominal returns.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_count <= 5'h00;
    end else if (ce) begin
      if (write_cmd && dyn_enabled && start_count == 5'h00
          && (!use_write || end_count == 5'h01)) begin
        start_count <= lat;
      end else if (start_count != 5'h00) begin
        start_count <= start_count - 5'h01;
      end
    end
  end

  // End countdown: every write with write strength enabled reloads it, so the latest such write sets the end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_count <= 5'h00;
    end else if (ce) begin
      if (write_cmd && dyn_enabled) begin
        end_count <= lat + (link.cmd_chop ? `CHOP_RETURN : `FULL_RETURN);
      end else if (end_count != 5'h00) begin
        end_count <= end_count - 5'h01;
      end
    end
  end

  // Window flag: set when the start count expires, cleared when the end does.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_write <= 1'b0;
    end else if (ce) begin
      if (end_count == 5'h01) begin
        use_write <= 1'b0;
      end else if (start_count == 5'h01) begin
        use_write <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settling after a mode-one load.

  // Covers latency, sub-clock skew, mode-set delay and one extra clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_count <= 8'h00;
    end else if (ce) begin
      if (mode1_cmd) begin
        settle_count <= 8'({3'h0, lat}) + 8'({3'h0, `SKEW_CLOCKS})
                        + 8'(MODE_SET_CYCLES) + 8'({3'h0, `EXTRA_CLOCKS});
      end else if (settle_count != 8'h00) begin
        settle_count <= settle_count - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage.

  // Strength selection per lane group; leveling keeps data lanes bare.
  always_comb begin
    if (leveling) begin
      next_dq     = RTT_OFF;
      next_strobe = nom_rtt;
    end else if (use_write) begin
      next_dq     = wr_rtt;
      next_strobe = wr_rtt;
    end else begin
      next_dq     = nom_rtt;
      next_strobe = nom_rtt;
    end
  end

  // Registered outputs; termination on only when gated and a strength exists.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_strength     <= RTT_OFF;
      strobe_strength <= RTT_OFF;
      dq_term_on      <= 1'b0;
      strobe_term_on  <= 1'b0;
      term_changing   <= 1'b0;
      term_uncertain  <= 1'b0;
    end else if (ce) begin
      dq_strength     <= next_dq;
      strobe_strength <= next_strobe;
      dq_term_on      <= ctl_delayed && next_dq != RTT_OFF;
      strobe_term_on  <= ctl_delayed && next_strobe != RTT_OFF;
      term_changing   <= start_count == 5'h01;
      term_uncertain  <= mode1_cmd || settle_count > 8'h01;
    end
  end
endmodule

// >>> logic/dyn_term_controller.sv
/*
 * Controller end: APB register file that issues link commands and drives the
 * termination control input with its minimum high times.
 * Assumes an APB master on pclk and the device end joined by the bench.
 */
`timescale 1ns/100ps
`include "dyn_term_defines.svh"

module dyn_term_controller (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  term_link_if.controller   link
);
  import dyn_term_pkg::*;

  logic        access;
  logic        commit;
  logic [3:0]  hold_load;
  logic        wr_cmd;
  logic        auto_ctl;
  logic        tied_high;
  logic        dll_off;
  logic        level_on;
  logic [12:0] mr1_shadow;
  logic [12:0] mr2_shadow;
  logic [3:0]  hold_count;
  logic        wr_stripped;
  logic        nom_warn;
  logic        nom_stripped;
  logic [12:0] cmd_data;
  logic [1:0]  cmd_sel;
  logic [12:0] next_data;
  logic        is_write;

  // Reads are prepared in the first access cycle; writes land at the
  // completing edge, where pready is seen high.
  assign access    = psel && penable && !pready;
  assign commit    = psel && penable && pready;
  assign wr_cmd    = commit && pwrite && paddr == `REG_CMD;
  assign hold_load = pwdata[`CMD_CHOP_BIT] ? `HIGH_TIME_SHORT : `HIGH_TIME_LONG;
  assign cmd_data  = pwdata[`CMD_DATA_LO +: 13];
  assign cmd_sel   = pwdata[`CMD_SEL_LO +: 2];
  assign is_write  = pwdata[`CMD_KIND_LO +: 2] == CMD_WRITE;

  ////////////////////////////////////////////////////////////////////////////
  // Mode data policing before it goes out.

  // Strips write strength without DLL or during leveling; in tied-high use
  // nominal is allowed only together with leveling.
  always_comb begin
    next_data = cmd_data;
    if (cmd_sel == 2'h2 && (dll_off || level_on)) begin
      next_data[`MR2_WR_HI] = 1'b0;
      next_data[`MR2_WR_LO] = 1'b0;
    end
    if (cmd_sel == 2'h1 && tied_high && !cmd_data[`MR1_LEVEL_BIT]) begin
      next_data[`MR1_NOM_HI]  = 1'b0;
      next_data[`MR1_NOM_MID] = 1'b0;
      next_data[`MR1_NOM_LO]  = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, registered answer.

  // Answer timing and read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready  <= access;
      pslverr <= access && paddr > `REG_MR2_SHADOW;
      prdata  <= 32'h00000000;
      if (access && !pwrite) begin
        unique case (paddr)
          `REG_TERM_CTRL:  prdata <= {30'h0, tied_high, auto_ctl};
          `REG_STATUS:     prdata <= {27'h0, nom_stripped, nom_warn, wr_stripped,
                                      link.termination_control_input, hold_count != 4'h0};
          `REG_MR1_SHADOW: prdata <= {19'h0, mr1_shadow};
          `REG_MR2_SHADOW: prdata <= {19'h0, mr2_shadow};
          default:         prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Control register and sticky status; a write of one clears a flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_ctl     <= 1'b0;
      tied_high    <= 1'b0;
      wr_stripped  <= 1'b0;
      nom_warn     <= 1'b0;
      nom_stripped <= 1'b0;
    end else if (ce) begin
      if (commit && pwrite && paddr == `REG_TERM_CTRL) begin
        auto_ctl  <= pwdata[0];
        tied_high <= pwdata[1];
      end
      if (commit && pwrite && paddr == `REG_STATUS) begin
        wr_stripped  <= wr_stripped  && !pwdata[`ST_WR_STRIPPED];
        nom_warn     <= nom_warn     && !pwdata[`ST_NOM_WARN];
        nom_stripped <= nom_stripped && !pwdata[`ST_NOM_STRIPPED];
      end
      // Set wins over a clear in the same cycle.
      if (wr_cmd && cmd_sel == 2'h2 && next_data != cmd_data) begin
        wr_stripped <= 1'b1;
      end
      if (wr_cmd && cmd_sel == 2'h1 && next_data != cmd_data) begin
        nom_stripped <= 1'b1;
      end
      if (wr_cmd && is_write && mr2_shadow[`MR2_WR_HI:`MR2_WR_LO] == 2'h0
          && !({mr1_shadow[`MR1_NOM_HI], mr1_shadow[`MR1_NOM_MID], mr1_shadow[`MR1_NOM_LO]}
               inside {3'h0, 3'h1, 3'h2, 3'h3})) begin
        nom_warn <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link command issue and mode shadows.

  // A command register write of any kind but none becomes a one-cycle link command.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.cmd_valid <= 1'b0;
      link.cmd_kind  <= CMD_NONE;
      link.cmd_chop  <= 1'b0;
      link.mr_sel    <= 2'h0;
      link.mr_data   <= 13'h0000;
      mr1_shadow     <= 13'h0000;
      mr2_shadow     <= 13'h0000;
      dll_off        <= 1'b0;
      level_on       <= 1'b0;
    end else if (ce) begin
      link.cmd_valid <= wr_cmd && pwdata[`CMD_KIND_LO +: 2] != CMD_NONE;
      if (wr_cmd) begin
        link.cmd_kind <= cmd_kind_t'(pwdata[`CMD_KIND_LO +: 2]);
        link.cmd_chop <= pwdata[`CMD_CHOP_BIT];
        link.mr_sel   <= cmd_sel;
        link.mr_data  <= next_data;
        if (pwdata[`CMD_KIND_LO +: 2] == CMD_MODE && cmd_sel == 2'h1) begin
          mr1_shadow <= next_data;
          dll_off    <= next_data[`MR1_DLL_OFF_BIT];
          level_on   <= next_data[`MR1_LEVEL_BIT];
        end
        if (pwdata[`CMD_KIND_LO +: 2] == CMD_MODE && cmd_sel == 2'h2) begin
          mr2_shadow <= next_data;
        end
      end
    end
  end

  // Control input: raised with each write while auto_ctl or tied_high is set, held for its minimum high time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_count                     <= 4'h0;
      link.termination_control_input <= 1'b0;
    end else if (ce) begin
      if (wr_cmd && is_write && (auto_ctl || tied_high)) begin
        // A later, shorter hold never cuts an earlier, longer one.
        hold_count <= (hold_load >= hold_count) ? hold_load : hold_count - 4'h1;
        link.termination_control_input <= 1'b1;
      end else if (hold_count > 4'h1) begin
        hold_count <= hold_count - 4'h1;
      end else begin
        hold_count <= 4'h0;
        link.termination_control_input <= tied_high;
      end
    end
  end
endmodule

// >>> sim/dyn_term_props.sv
/*
 * Checker of the termination link and of the device end's outputs.
 * Assumes ce high, mode latencies left at reset (turn-on latency 3) and
 * a mode-set delay parameter of 2, so that settling takes 7 cycles.
 */
`timescale 1ns/100ps
module dyn_term_props
  import dyn_term_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  cmd_valid,
  input wire dyn_term_pkg::cmd_kind_t cmd_kind,
  input wire logic                  cmd_chop,
  input wire logic [1:0]            mr_sel,
  input wire logic [12:0]           mr_data,
  input wire logic                  termination_control_input,
  input wire dyn_term_pkg::rtt_t    dq_strength,
  input wire logic                  dq_term_on,
  input wire logic                  term_changing,
  input wire logic                  term_uncertain
);
  import dyn_term_pkg::*;
  localparam int L = 3;
  logic [12:0] mr1;
  logic [1:0]  wc;
  rtt_t        nq, nom_now, wr_rtt;
  int          rem, lenr;
  logic        wr_go, ld1;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  // Decoded commands and the strengths they select.
  assign ld1     = cmd_valid && cmd_kind == CMD_MODE && mr_sel == 2'h1;
  assign wr_go   = cmd_valid && cmd_kind == CMD_WRITE && wc != 2'h0;
  assign wr_rtt  = wc == 2'h1 ? RTT_DIV4 : (wc == 2'h2 ? RTT_DIV2 : RTT_RESERVED);
  assign nom_now = {mr1[9], mr1[6], mr1[2]} > 3'h5 ? RTT_RESERVED
                 : rtt_t'({mr1[9], mr1[6], mr1[2]});

  // Shadow of the mode registers as loaded over the link.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr1 <= 13'h0000;
      wc  <= 2'h0;
    end else if (cmd_valid && cmd_kind == CMD_MODE && mr_sel == 2'h1) begin
      mr1 <= mr_data;
    end else if (cmd_valid && cmd_kind == CMD_MODE && mr_sel == 2'h2) begin
      wc <= mr_data[10:9];
    end
  end

  // Nominal strength delayed to line up with the output register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nq <= RTT_OFF;
    end else begin
      nq <= nom_now;
    end
  end

  // Cycles left until the latest write's window has left the outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem  <= 0;
      lenr <= 0;
    end else if (wr_go) begin
      rem  <= L + (cmd_chop ? 4 : 6) + 1;
      lenr <= cmd_chop ? 4 : 6;
    end else if (rem != 0) begin
      rem <= rem - 1;
    end
  end

  ////////////////////////////////////////
  property p_onset;
    wr_go && rem == 0 |-> ##4 (term_changing && dq_strength == nq)
      ##1 (!term_changing && dq_strength == wr_rtt);
  endproperty
  a_onset: assert property (p_onset) else $error("write strength onset wrong");
  property p_hold;
    rem >= 1 && rem <= lenr |-> dq_strength == wr_rtt;
  endproperty
  a_hold: assert property (p_hold) else $error("write strength not held");
  property p_return;
    rem == 1 |=> dq_strength == nq;
  endproperty
  a_return: assert property (p_return) else $error("nominal not restored");
  property p_nominal;
    rem == 0 && !term_uncertain && !mr1[7] |-> dq_strength == nq;
  endproperty
  a_nominal: assert property (p_nominal) else $error("nominal strength wrong");
  property p_term_on;
    nq != RTT_OFF && !term_uncertain && !mr1[7]
      |-> dq_term_on == $past(termination_control_input, 5);
  endproperty
  a_term_on: assert property (p_term_on) else $error("termination gating wrong");
  property p_uncertain;
    ld1 |=> term_uncertain [*7];
  endproperty
  a_uncertain: assert property (p_uncertain) else $error("settling flag short");
  property p_ctl_min;
    $rose(termination_control_input) |-> termination_control_input [*4];
  endproperty
  a_ctl_min: assert property (p_ctl_min) else $error("control input too short");
  property p_ctl_full;
    cmd_valid && cmd_kind == CMD_WRITE && !cmd_chop && termination_control_input
      |-> termination_control_input [*6];
  endproperty
  a_ctl_full: assert property (p_ctl_full) else $error("long hold too short");
  property p_police;
    cmd_valid && cmd_kind == CMD_MODE && mr_sel == 2'h2 && (mr1[0] || mr1[7])
      |-> mr_data[10:9] == 2'h0;
  endproperty
  a_police: assert property (p_police) else $error("write strength sent");

  // Main scenarios.
  c_overlap: cover property (wr_go && rem != 0);
  c_level:   cover property (ld1 && mr_data[7]);
  c_return:  cover property (rem == 1);
endmodule

// >>> sim/tb.sv
/*
 * Testbench: APB master on the controller, both ends joined by the link,
 * a cycle model of the data-lane strength compared at every edge while mon is set and term_uncertain is not high.
 * Assumes the design files and the checker are compiled before it.
 */
`timescale 1ns/100ps
`include "dyn_term_defines.svh"
module tb;
  import dyn_term_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  rtt_t        dq_strength, strobe_strength, p1, p2;
  logic        dq_term_on, strobe_term_on, term_changing, term_uncertain;
  logic        mon, w, wp, tc1;
  logic [12:0] mr1m, mr2m;
  logic [2:0]  c;
  int          err_count, n_checks, seed, i, k, wst, wend;

  term_link_if link ();
  dyn_term_controller dyn_term_controller_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  dyn_term_device #(.MODE_SET_CYCLES(2)) dyn_term_device_inst (.pclk(pclk),
    .presetn(presetn), .ce(ce), .link(link), .dq_strength(dq_strength),
    .strobe_strength(strobe_strength), .dq_term_on(dq_term_on),
    .strobe_term_on(strobe_term_on), .term_changing(term_changing),
    .term_uncertain(term_uncertain));
  dyn_term_props dyn_term_props_inst (.pclk(pclk), .presetn(presetn),
    .cmd_valid(link.cmd_valid), .cmd_kind(link.cmd_kind), .cmd_chop(link.cmd_chop),
    .mr_sel(link.mr_sel), .mr_data(link.mr_data),
    .termination_control_input(link.termination_control_input),
    .dq_strength(dq_strength), .dq_term_on(dq_term_on), .term_changing(term_changing),
    .term_uncertain(term_uncertain));

  ////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk32(input string s, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic chk_rtt(input string s, input rtt_t x, input rtt_t g);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask
  // One APB transfer; lets an edge pass after any release, held until pready.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string s, input logic [11:0] a, input logic [31:0] x,
                    input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk32(s, x, r & m);
  endtask
  task automatic cmd(input cmd_kind_t kd, input logic ch, input logic [1:0] s,
                     input logic [12:0] d);
    apb(1'b1, `REG_CMD, {3'h0, d, 11'h000, s, ch, kd});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic rtt_t nmap(input logic [12:0] d);
    return {d[9], d[6], d[2]} > 3'h5 ? RTT_RESERVED : rtt_t'({d[9], d[6], d[2]});
  endfunction
  function automatic rtt_t wmap(input logic [1:0] d);
    return d == 2'h1 ? RTT_DIV4 : (d == 2'h2 ? RTT_DIV2 : RTT_RESERVED);
  endfunction

  ////////////////////////////////////////
  // Clock of 5 ns.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Cycle model of the data-lane strength and the switch marker.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {k, wst, wend, wp, tc1, mr1m, mr2m} = '0;
      p1 = RTT_OFF;
      p2 = RTT_OFF;
    end else begin
      if (mon && term_uncertain !== 1'b1) begin
        chk_rtt("dq_strength", p2, dq_strength);
        chk32("term_changing", {31'h0, tc1}, {31'h0, term_changing});
      end
      if (link.cmd_valid && link.cmd_kind == CMD_MODE && link.mr_sel == 2'h1) mr1m = link.mr_data;
      if (link.cmd_valid && link.cmd_kind == CMD_MODE && link.mr_sel == 2'h2) mr2m = link.mr_data;
      if (link.cmd_valid && link.cmd_kind == CMD_WRITE && mr2m[10:9] != 2'h0) begin
        if (k >= wend) wst = k + 3;
        wend = k + 3 + (link.cmd_chop ? 4 : 6);
      end
      w = k >= wst && k < wend;
      tc1 = w && !wp;
      wp = w;
      p2 = p1;
      p1 = w ? wmap(mr2m[10:9]) : nmap(mr1m);
      k++;
    end
  end

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, err_count, n_checks} = '0;
    ce = 1'b1;
    mon = 1'b1;
    seed = 32'h6e54;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("status", `REG_STATUS, 32'h0, 32'h1F);
    apb(1'b0, 12'h014, 32'h0);
    chk32("unmapped", 32'h1, {r, e} == 33'h1);
    apb(1'b1, `REG_TERM_CTRL, 32'h1);
    rd("term_ctrl", `REG_TERM_CTRL, 32'h1, 32'h3);
    for (i = 1; i <= 5; i++) begin
      c = i[2:0];
      cmd(CMD_MODE, 1'b0, 2'h1, {3'h0, c[2], 2'h0, c[1], 3'h0, c[0], 2'h0});
      cmd(CMD_MODE, 1'b0, 2'h2, {2'h0, 2'(i % 4), 9'h000});
      rd("mr2_shadow", `REG_MR2_SHADOW, {21'h0, 2'(i % 4), 9'h0}, 32'h1FFF);
      idle(10);
      repeat (5) begin
        cmd(CMD_WRITE, 1'($random(seed)), 2'h0, 13'h0000);
        if ($random(seed) & 1) idle(14);
      end
      idle(16);
    end
    cmd(CMD_MODE, 1'b0, 2'h1, 13'h0001);
    cmd(CMD_MODE, 1'b0, 2'h2, 13'h0200);
    rd("mr2_stripped", `REG_MR2_SHADOW, 32'h0, 32'h1FFF);
    rd("stripped_flag", `REG_STATUS, 32'hC, 32'h1C);
    apb(1'b1, `REG_STATUS, 32'h1C);
    rd("flag_cleared", `REG_STATUS, 32'h0, 32'h1C);
    cmd(CMD_WRITE, 1'b0, 2'h0, 13'h0000);
    idle(16);
    apb(1'b1, `REG_TERM_CTRL, 32'h2);
    cmd(CMD_MODE, 1'b0, 2'h1, 13'h0044);
    rd("tied_input", `REG_STATUS, 32'h2, 32'h2);
    rd("nom_stripped", `REG_MR1_SHADOW, 32'h0, 32'h0244);
    cmd(CMD_MODE, 1'b0, 2'h2, 13'h0200);
    cmd(CMD_WRITE, 1'b1, 2'h0, 13'h0000);
    idle(16);
    mon = 1'b0;
    cmd(CMD_MODE, 1'b0, 2'h2, 13'h0000);
    cmd(CMD_MODE, 1'b0, 2'h1, 13'h00C4);
    idle(12);
    chk_rtt("strobe_strength", RTT_DIV6, strobe_strength);
    chk32("level_on", 32'h1, {dq_term_on, strobe_term_on});
    cmd(CMD_MODE, 1'b0, 2'h1, 13'h0000);
    idle(12);
    chk32("level_off", 32'h0, {dq_term_on, strobe_term_on});
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    mon = 1'b1;
    idle(2);
    chk_rtt("reset_strength", RTT_OFF, dq_strength);
    end_sim();
  end
endmodule
